// file: inc/hwn_pkg.sv
package hwn_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int HWN_CLK_NS = 5; // mclk period
    localparam int HWN_T_SPI_EN_NS = 1000; // strap low time for serial enable
    localparam int HWN_SPI_EN_CYC = (HWN_T_SPI_EN_NS + HWN_CLK_NS - 1) / HWN_CLK_NS; // least
    localparam int HWN_T_LEAD_NS = 100; // supply enable lead before notify
    localparam int HWN_LEAD_CYC = (HWN_T_LEAD_NS + HWN_CLK_NS - 1) / HWN_CLK_NS;
    localparam int HWN_T_NOTIFY_NS = 400; // notify pulse width
    localparam int HWN_NOTIFY_CYC = (HWN_T_NOTIFY_NS + HWN_CLK_NS - 1) / HWN_CLK_NS;
    localparam int HWN_T_SCLK_NS = 80; // host serial clock period
    localparam int HWN_SCLK_HALF = HWN_T_SCLK_NS / (2 * HWN_CLK_NS); // half period, cycles
    localparam int HWN_FRAME_BITS = 16; // clocks per frame
    localparam int HWN_TIM_W = 16; // width of the timers
    localparam int HWN_SYNC_CYC = 4; // cycles for a pin level to pass the synchroniser

    // ------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HWN_DV_IDLE = 3'b000,
        HWN_DV_WAKE = 3'b001,
        HWN_DV_READY = 3'b010,
        HWN_DV_LEAD = 3'b011,
        HWN_DV_NOTIFY = 3'b100
    } hwn_dev_st_type;

    typedef enum logic [2:0] {
        HWN_HS_IDLE = 3'b000,
        HWN_HS_WAKE = 3'b001,
        HWN_HS_SESS = 3'b010,
        HWN_HS_SHIFT = 3'b011,
        HWN_HS_GAP = 3'b100
    } hwn_host_st_type;
endpackage : hwn_pkg

// file: inc/hwn_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hwn_if;
    // ------------------------------------------------------------
    // driven pieces of each pin
    // ------------------------------------------------------------
    logic cs_o; // host drive of wake/select
    logic cs_oe; // host enable, low when isolated
    logic cs_pu_en; // device pull-up on wake/select
    logic sclk; // serial clock from host
    logic soci; // host to device data
    logic sico_o; // device to host data
    logic sico_oe;
    logic rdy_o; // ready/notify drive
    logic rdy_oe;
    logic rdy_pd_en; // host pull-down on ready/notify
    logic pse_o; // supply_enable_out drive
    logic pse_oe;
    // ------------------------------------------------------------
    // resolved wire levels
    // ------------------------------------------------------------
    wire logic cs; // port_a_line0, pulled high when undriven
    wire logic sico;
    wire logic rdy; // port_b_line0, pulled to idle low
    wire logic pse; // port_b_line1, external idle low
    assign cs = cs_oe ? cs_o : 1'b1;
    assign sico = sico_oe ? sico_o : 1'b0;
    assign rdy = rdy_oe ? rdy_o : 1'b0;
    assign pse = pse_oe ? pse_o : 1'b0;

    modport dev (input cs, input sclk, input soci, output cs_pu_en, output sico_o,
        output sico_oe, output rdy_o, output rdy_oe, output pse_o, output pse_oe);
    modport host (output cs_o, output cs_oe, output sclk, output soci, output rdy_pd_en,
        input sico, input rdy, input pse);
endinterface : hwn_if
`default_nettype wire

// file: verilog/hwn_device.sv
// How it works
// - supply enable asserted before a notify pulse when the supply function is on
// - low wake level requests interrupt, no edge
// - ready asserted after wake is recognised
// - internal event gives notify pulse on pin
// - host drives wake low to start
// - enabled port: low select accepts serial frames
// - host pulls ready pin to idle level
// - sleep: pull-up on wake, others released
// - outside keeps supply enable idle in sleep
// - held low select halts new measurements
// - enable by control bit or strap
// - mode zero, rising capture, sixteen clocks
`timescale 1ns/1ps
`default_nettype none
module hwn_device import hwn_pkg::*; #(
    parameter int SPI_EN_CYC = HWN_SPI_EN_CYC,
    parameter int LEAD_CYC = HWN_LEAD_CYC,
    parameter int NOTIFY_CYC = HWN_NOTIFY_CYC,
    parameter int FRAME_BITS = HWN_FRAME_BITS
) (
    input wire logic mclk,
    input wire logic nrst,
    hwn_if.dev link,
    input wire logic sleep_req,
    input wire logic serial_port_enable_bit,
    input wire logic supply_fn_en,
    input wire logic event_req,
    input wire logic [FRAME_BITS-1:0] tx_word,
    output logic wake_irq,
    output logic serial_enabled,
    output logic meas_hold,
    output logic frame_done,
    output logic [FRAME_BITS-1:0] rx_word
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_in; // cs, sclk, soci
    logic [2:0] s1_r, s2_r, s3_r; // three stage chain
    logic [2:0] f_r; // filtered level
    logic [2:0] fp_r; // filtered level, one cycle late
    assign pin_in = {link.cs, link.sclk, link.soci};

    // a change only counts once stages two and three agree
    for (genvar gi = 0; gi < 3; gi++) begin : g_sync
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                // idle levels: select high, clock and data low, so no false edge
                s1_r[gi] <= (gi == 2);
                s2_r[gi] <= (gi == 2);
                s3_r[gi] <= (gi == 2);
                f_r[gi] <= (gi == 2);
                fp_r[gi] <= (gi == 2);
            end else begin
                s1_r[gi] <= pin_in[gi];
                s2_r[gi] <= s1_r[gi];
                s3_r[gi] <= s2_r[gi];
                if (s2_r[gi] == s3_r[gi]) begin
                    f_r[gi] <= s3_r[gi];
                end
                fp_r[gi] <= f_r[gi];
            end
        end
    end

    logic cs_low, cs_fall, sclk_rise, sclk_fall;
    assign cs_low = ~f_r[2];
    assign cs_fall = fp_r[2] & ~f_r[2];
    assign sclk_rise = ~fp_r[1] & f_r[1];
    assign sclk_fall = fp_r[1] & ~f_r[1];

    // ------------------------------------------------------------
    // power-on strap enable
    // ------------------------------------------------------------
    logic [HWN_TIM_W-1:0] strap_cnt_r, strap_cnt_nxt; // low time so far
    logic strap_open_r, strap_open_nxt; // window closes at first high
    logic strap_r, strap_nxt; // port enabled by strap

    // counts from reset release, so a late low never enables
    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        strap_open_nxt = strap_open_r;
        strap_nxt = strap_r;
        if (strap_open_r) begin
            strap_cnt_nxt = strap_cnt_r + 1'b1;
            // the synchroniser shows its reset level for the first cycles
            if (strap_cnt_r >= HWN_TIM_W'(HWN_SYNC_CYC) && !cs_low) begin
                strap_open_nxt = 1'b0; // released too early
            end else if (strap_cnt_r == HWN_TIM_W'(SPI_EN_CYC + HWN_SYNC_CYC)) begin
                strap_nxt = 1'b1;
                strap_open_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            strap_cnt_r <= '0;
            strap_open_r <= 1'b1;
            strap_r <= 1'b0;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            strap_open_r <= strap_open_nxt;
            strap_r <= strap_nxt;
        end
    end

    logic port_en;
    assign port_en = serial_port_enable_bit | strap_r;

    // ------------------------------------------------------------
    // wake, ready and notify sequencer
    // ------------------------------------------------------------
    hwn_dev_st_type st_r, st_nxt;
    logic [HWN_TIM_W-1:0] tim_r, tim_nxt; // lead and pulse timer
    logic pend_r, pend_nxt; // notify waiting
    logic rdy_oe_r, rdy_oe_nxt;
    logic pse_o_r, pse_o_nxt;
    logic pse_oe_r, pse_oe_nxt;
    logic wake_r, wake_nxt;

    always_comb begin
        st_nxt = st_r;
        tim_nxt = tim_r;
        pend_nxt = pend_r;
        unique case (st_r)
            HWN_DV_IDLE: begin
                tim_nxt = '0;
                if (cs_low && !port_en) begin
                    st_nxt = HWN_DV_WAKE; // level, not edge
                end else if (pend_r && !sleep_req && !cs_low) begin
                    // supply goes up first when the function is on
                    st_nxt = supply_fn_en ? HWN_DV_LEAD : HWN_DV_NOTIFY;
                    pend_nxt = 1'b0;
                end
            end
            HWN_DV_WAKE: begin
                if (!cs_low) begin
                    st_nxt = HWN_DV_IDLE; // request withdrawn
                end else if (port_en) begin
                    st_nxt = HWN_DV_READY;
                end
            end
            HWN_DV_READY: begin
                if (!cs_low) begin
                    st_nxt = HWN_DV_IDLE;
                end
            end
            HWN_DV_LEAD: begin
                tim_nxt = tim_r + 1'b1;
                if (tim_r == HWN_TIM_W'(LEAD_CYC - 1)) begin
                    st_nxt = HWN_DV_NOTIFY;
                    tim_nxt = '0;
                end
            end
            HWN_DV_NOTIFY: begin
                tim_nxt = tim_r + 1'b1;
                if (tim_r == HWN_TIM_W'(NOTIFY_CYC - 1)) begin
                    st_nxt = HWN_DV_IDLE;
                    tim_nxt = '0;
                end
            end
        endcase
        // a new event in the taking cycle still counts
        if (event_req) begin
            pend_nxt = 1'b1;
        end
        // sleep releases every driven pin; only the pull-up stays
        rdy_oe_nxt = !sleep_req && (st_nxt == HWN_DV_READY || st_nxt == HWN_DV_NOTIFY);
        pse_oe_nxt = !sleep_req && supply_fn_en;
        pse_o_nxt = (st_nxt == HWN_DV_LEAD) || (st_nxt == HWN_DV_NOTIFY);
        wake_nxt = cs_low && !port_en;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= HWN_DV_IDLE;
            tim_r <= '0;
            pend_r <= 1'b0;
            rdy_oe_r <= 1'b0;
            pse_o_r <= 1'b0;
            pse_oe_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tim_r <= tim_nxt;
            pend_r <= pend_nxt;
            rdy_oe_r <= rdy_oe_nxt;
            pse_o_r <= pse_o_nxt;
            pse_oe_r <= pse_oe_nxt;
            wake_r <= wake_nxt;
        end
    end

    // ------------------------------------------------------------
    // serial frame engine
    // ------------------------------------------------------------
    logic [4:0] bc_r, bc_nxt; // rising edges seen this frame
    logic [FRAME_BITS-1:0] tsh_r, tsh_nxt; // outgoing shifter
    logic [FRAME_BITS-1:0] rsh_r, rsh_nxt; // incoming shifter
    logic [FRAME_BITS-1:0] rxw_r, rxw_nxt;
    logic done_r, done_nxt;
    logic sico_oe_r, sico_oe_nxt;
    logic sel;
    assign sel = port_en && cs_low;

    // capture on rise, change on fall; first bit set up by select
    always_comb begin
        bc_nxt = bc_r;
        tsh_nxt = tsh_r;
        rsh_nxt = rsh_r;
        rxw_nxt = rxw_r;
        done_nxt = 1'b0;
        if (!sel) begin
            bc_nxt = '0;
        end else if (cs_fall) begin
            tsh_nxt = tx_word;
            bc_nxt = '0;
        end else if (sclk_rise) begin
            rsh_nxt = {rsh_r[FRAME_BITS-2:0], f_r[0]};
            bc_nxt = bc_r + 1'b1;
            if (bc_r == 5'(FRAME_BITS - 1)) begin
                // sixteenth clock closes the frame
                rxw_nxt = {rsh_r[FRAME_BITS-2:0], f_r[0]};
                done_nxt = 1'b1;
                bc_nxt = '0;
                tsh_nxt = tx_word;
            end
        end else if (sclk_fall && bc_r != '0) begin
            tsh_nxt = {tsh_r[FRAME_BITS-2:0], 1'b0};
        end else if (bc_r == '0) begin
            tsh_nxt = tx_word; // select may already be low, so track until first rise
        end
        sico_oe_nxt = sel && !sleep_req;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bc_r <= '0;
            tsh_r <= '0;
            rsh_r <= '0;
            rxw_r <= '0;
            done_r <= 1'b0;
            sico_oe_r <= 1'b0;
        end else begin
            bc_r <= bc_nxt;
            tsh_r <= tsh_nxt;
            rsh_r <= rsh_nxt;
            rxw_r <= rxw_nxt;
            done_r <= done_nxt;
            sico_oe_r <= sico_oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.cs_pu_en = 1'b1; // pull-up kept, also in sleep
    assign link.rdy_o = 1'b1; // only driven while asserted
    assign link.rdy_oe = rdy_oe_r;
    assign link.pse_o = pse_o_r;
    assign link.pse_oe = pse_oe_r;
    assign link.sico_o = tsh_r[FRAME_BITS-1];
    assign link.sico_oe = sico_oe_r;
    assign wake_irq = wake_r;
    assign serial_enabled = port_en;
    // a stuck low select freezes measuring, so hosts must isolate it
    assign meas_hold = cs_low;
    assign frame_done = done_r;
    assign rx_word = rxw_r;
endmodule : hwn_device
`default_nettype wire

// file: verilog/hwn_host.sv
`timescale 1ns/1ps
`default_nettype none
module hwn_host import hwn_pkg::*; #(
    parameter int SCLK_HALF = HWN_SCLK_HALF,
    parameter int FRAME_BITS = HWN_FRAME_BITS
) (
    input wire logic mclk,
    input wire logic nrst,
    hwn_if.host link,
    input wire logic wake_req,
    input wire logic host_off,
    input wire logic start,
    input wire logic [FRAME_BITS-1:0] tx_word,
    output logic busy,
    output logic done,
    output logic [FRAME_BITS-1:0] rx_word,
    output logic ready_seen,
    output logic notify_seen,
    output logic supply_seen
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_in; // rdy, sico, pse
    logic [2:0] s1_r, s2_r, s3_r, f_r, fp_r;
    assign pin_in = {link.rdy, link.sico, link.pse};

    for (genvar gi = 0; gi < 3; gi++) begin : g_sync
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                s1_r[gi] <= 1'b0;
                s2_r[gi] <= 1'b0;
                s3_r[gi] <= 1'b0;
                f_r[gi] <= 1'b0;
                fp_r[gi] <= 1'b0;
            end else begin
                s1_r[gi] <= pin_in[gi];
                s2_r[gi] <= s1_r[gi];
                s3_r[gi] <= s2_r[gi];
                if (s2_r[gi] == s3_r[gi]) begin
                    f_r[gi] <= s3_r[gi];
                end
                fp_r[gi] <= f_r[gi];
            end
        end
    end

    // ------------------------------------------------------------
    // session and frame sequencer
    // ------------------------------------------------------------
    hwn_host_st_type st_r, st_nxt;
    logic [7:0] dv_r, dv_nxt; // half period divider
    logic sclk_r, sclk_nxt;
    logic [4:0] bc_r, bc_nxt; // falls completed
    logic [FRAME_BITS-1:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt, rxw_r, rxw_nxt;
    logic done_r, done_nxt, ntf_r, ntf_nxt;

    always_comb begin
        st_nxt = st_r;
        dv_nxt = dv_r;
        sclk_nxt = sclk_r;
        bc_nxt = bc_r;
        tsh_nxt = tsh_r;
        rsh_nxt = rsh_r;
        rxw_nxt = rxw_r;
        done_nxt = 1'b0;
        // rising ready outside a wake request is a notify pulse
        ntf_nxt = f_r[2] && !fp_r[2] && st_r == HWN_HS_IDLE;
        unique case (st_r)
            HWN_HS_IDLE: begin
                dv_nxt = '0;
                if (start && !host_off) begin
                    st_nxt = HWN_HS_SHIFT;
                    tsh_nxt = tx_word;
                    bc_nxt = '0;
                end else if (wake_req && !host_off) begin
                    st_nxt = HWN_HS_WAKE; // select low as wake
                end
            end
            HWN_HS_WAKE: begin
                if (!wake_req) begin
                    st_nxt = HWN_HS_IDLE;
                end else if (f_r[2]) begin
                    st_nxt = HWN_HS_SESS; // device ready
                end
            end
            HWN_HS_SESS: begin
                if (start) begin
                    st_nxt = HWN_HS_SHIFT;
                    tsh_nxt = tx_word;
                    bc_nxt = '0;
                    dv_nxt = '0;
                end else if (!wake_req) begin
                    st_nxt = HWN_HS_IDLE;
                end
            end
            HWN_HS_SHIFT: begin
                dv_nxt = dv_r + 1'b1;
                if (dv_r == 8'(SCLK_HALF - 1)) begin
                    dv_nxt = '0;
                    sclk_nxt = !sclk_r;
                    // sico is read just before each fall: the round trip through
                    // both synchronisers is longer than half a clock period
                    if (sclk_r) begin
                        rsh_nxt = {rsh_r[FRAME_BITS-2:0], f_r[1]};
                    end
                    if (sclk_r && bc_r == 5'(FRAME_BITS - 1)) begin
                        rxw_nxt = {rsh_r[FRAME_BITS-2:0], f_r[1]};
                        done_nxt = 1'b1;
                        st_nxt = HWN_HS_GAP; // select strobes high
                    end else if (sclk_r) begin
                        bc_nxt = bc_r + 1'b1;
                        tsh_nxt = {tsh_r[FRAME_BITS-2:0], 1'b0}; // change on fall
                    end
                end
            end
            HWN_HS_GAP: begin
                dv_nxt = dv_r + 1'b1;
                if (dv_r == 8'(SCLK_HALF - 1)) begin
                    dv_nxt = '0;
                    st_nxt = wake_req ? HWN_HS_SESS : HWN_HS_IDLE;
                end
            end
            default: begin
                st_nxt = HWN_HS_IDLE;
            end
        endcase
        if (host_off) begin
            st_nxt = HWN_HS_IDLE; // isolated, select released
            sclk_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= HWN_HS_IDLE;
            dv_r <= '0;
            sclk_r <= 1'b0;
            bc_r <= '0;
            tsh_r <= '0;
            rsh_r <= '0;
            rxw_r <= '0;
            done_r <= 1'b0;
            ntf_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            dv_r <= dv_nxt;
            sclk_r <= sclk_nxt;
            bc_r <= bc_nxt;
            tsh_r <= tsh_nxt;
            rsh_r <= rsh_nxt;
            rxw_r <= rxw_nxt;
            done_r <= done_nxt;
            ntf_r <= ntf_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.cs_o = (st_r == HWN_HS_IDLE) || (st_r == HWN_HS_GAP);
    assign link.cs_oe = !host_off;
    assign link.sclk = sclk_r; // idles low
    assign link.soci = tsh_r[FRAME_BITS-1];
    assign link.rdy_pd_en = 1'b1;
    assign busy = st_r == HWN_HS_SHIFT || st_r == HWN_HS_GAP;
    assign done = done_r;
    assign rx_word = rxw_r;
    assign ready_seen = f_r[2];
    assign notify_seen = ntf_r;
    assign supply_seen = f_r[0];
endmodule : hwn_host
`default_nettype wire

// file: sim/hwn_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// pin checker beside the link
// ----------
module hwn_chk #(
    parameter int NOTIFY_CYC = 80
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs,
    input wire logic sclk,
    input wire logic rdy,
    input wire logic pse,
    input wire logic pse_oe,
    input wire logic sico_oe,
    input wire logic cs_pu_en
);
    logic rdy_r; // last ready level
    logic sclk_r; // last clock level
    logic ntf_r, ntf_nxt; // pulse began with select high
    logic [7:0] hi_r, hi_nxt; // cycles ready stood high
    logic [4:0] clk_r, clk_nxt; // clock rises in this strobe
    // next values; counters clear when their cause ends
    always_comb begin
        ntf_nxt = rdy ? (ntf_r | (~rdy_r & cs)) : 1'b0;
        hi_nxt = rdy ? hi_r + 8'h01 : 8'h00;
        clk_nxt = cs ? 5'h00 : clk_r + {4'h0, sclk & ~sclk_r};
    end
    // helper registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdy_r <= 1'b0;
            sclk_r <= 1'b0;
            ntf_r <= 1'b0;
            hi_r <= 8'h00;
            clk_r <= 5'h00;
        end else begin
            rdy_r <= rdy;
            sclk_r <= sclk;
            ntf_r <= ntf_nxt;
            hi_r <= hi_nxt;
            clk_r <= clk_nxt;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // ----------
    // assertions
    // ----------
    pse_lead_a: assert property ($rose(rdy) && cs && pse_oe |-> pse && $past(pse, 10))
        else $error("supply enable not ahead of notify");
    pse_hold_a: assert property (rdy && ntf_r && pse_oe |-> pse)
        else $error("supply enable dropped in notify");
    pulse_len_a: assert property ($fell(rdy) && ntf_r |-> hi_r == NOTIFY_CYC)
        else $error("notify pulse width wrong");
    ready_hold_a: assert property (rdy && !cs && !ntf_r |=> rdy)
        else $error("ready dropped with select low");
    ready_drop_a: assert property ($rose(cs) && rdy && !ntf_r |-> ##[1:8] !rdy)
        else $error("ready kept after select release");
    sclk_idle_a: assert property (cs |-> !sclk)
        else $error("serial clock not idle low");
    frame_len_a: assert property ($rose(cs) |-> clk_r == 5'h10 || clk_r == 5'h00)
        else $error("frame clock count wrong");
    sico_rel_a: assert property (cs [*8] |-> !sico_oe)
        else $error("data out driven while unselected");
    pullup_on_a: assert property (cs_pu_en)
        else $error("select pull-up off");
    // main scenarios reached
    cover property ($fell(rdy) && ntf_r);
    cover property ($rose(cs) && clk_r == 5'h10);
    cover property ($rose(rdy) && !cs);
endmodule : hwn_chk
`default_nettype wire

// file: sim/host_wake_notify_handshake_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_wake_notify_handshake_tb import hwn_pkg::*;;
    logic mclk = 1'b0; // 200 MHz
    logic nrst; // host reset
    logic dev_nrst; // device reset, pulsed alone for the strap
    logic sleep_req, port_bit, fn_en, event_req, wake_req, host_off, start;
    logic [HWN_FRAME_BITS-1:0] dtx, htx, drx, hrx;
    logic wake_irq, port_on, meas_hold, fdone, hdone, rdy_seen, ntf_seen, sup_seen, hbusy;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0; // run length guard
    logic [15:0] q_dh[$], q_hd[$], rxq[$]; // model: words each way
    hwn_if link();
    always #2.5 mclk = ~mclk;
    // ----------
    // both ends and the checker
    // ----------
    hwn_device #(.SPI_EN_CYC(8), .NOTIFY_CYC(HWN_NOTIFY_CYC)) hwn_device_inst (.mclk(mclk),
        .nrst(dev_nrst), .link(link.dev), .sleep_req(sleep_req), .serial_port_enable_bit(port_bit),
        .supply_fn_en(fn_en), .event_req(event_req), .tx_word(dtx), .wake_irq(wake_irq),
        .serial_enabled(port_on), .meas_hold(meas_hold), .frame_done(fdone), .rx_word(drx));
    hwn_host hwn_host_inst (.mclk(mclk), .nrst(nrst), .link(link.host), .wake_req(wake_req),
        .host_off(host_off), .start(start), .tx_word(htx), .busy(hbusy), .done(hdone),
        .rx_word(hrx), .ready_seen(rdy_seen), .notify_seen(ntf_seen), .supply_seen(sup_seen));
    hwn_chk #(.NOTIFY_CYC(HWN_NOTIFY_CYC)) hwn_chk_inst (.mclk(mclk), .nrst(dev_nrst),
        .cs(link.cs), .sclk(link.sclk), .rdy(link.rdy), .pse(link.pse), .pse_oe(link.pse_oe),
        .sico_oe(link.sico_oe), .cs_pu_en(link.cs_pu_en));
    // device words land here at frame end
    always @(negedge mclk) if (fdone === 1'b1) rxq.push_back(drx);
    // about 1700 cycles expected; ceiling well above
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // ----------
    // shared tasks
    // ----------
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask : chk
    function automatic logic pick(input int sel);
        case (sel)
            0: return wake_irq;
            1: return rdy_seen;
            2: return hdone;
            default: return ntf_seen;
        endcase
    endfunction : pick
    // bounded wait, sampled mid-cycle so pulses are seen
    task automatic wt(input int sel, input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge mclk);
            seen = (pick(sel) === 1'b1);
        end
    endtask : wt
    // one full frame, both words random
    task automatic frame();
        logic ok;
        // host takes start from idle or once it has settled in its session
        @(negedge mclk);
        htx = 16'($urandom());
        dtx = 16'($urandom());
        q_dh.push_back(htx);
        q_hd.push_back(dtx);
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        chk("host busy", hbusy, 1'b1);
        wt(2, 600, ok);
        chk("host done", ok, 1'b1);
        chk("host word", hrx, q_hd.pop_front());
        repeat (12) @(negedge mclk);
        chk("device word", rxq.size() ? rxq.pop_front() : 16'hxxxx, q_dh.pop_front());
    endtask : frame
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // ----------
    // main sequence
    // ----------
    initial begin
        logic ok;
        void'($urandom(32'h2c5c));
        {nrst, dev_nrst, sleep_req, port_bit, fn_en, event_req, wake_req, host_off} = '0;
        start = 1'b0;
        htx = '0;
        dtx = '0;
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        dev_nrst = 1'b1;
        // wake level with the port still off
        wake_req = 1'b1;
        wt(0, 40, ok);
        chk("wake irq", ok, 1'b1);
        chk("ready early", rdy_seen, 1'b0);
        chk("meas hold", meas_hold, 1'b1);
        port_bit = 1'b1;
        wt(1, 40, ok);
        chk("ready", ok, 1'b1);
        chk("irq after enable", wake_irq, 1'b0);
        $display("test wake done");
        // back-to-back frames, then one from idle
        for (int k = 0; k < 3; k++) frame();
        wake_req = 1'b0;
        repeat (16) @(negedge mclk);
        chk("ready released", link.rdy, 1'b0);
        chk("hold released", meas_hold, 1'b0);
        frame();
        $display("test frames done");
        // notify with supply, without, and held off by sleep
        for (int m = 0; m < 3; m++) begin
            fn_en = (m != 1);
            sleep_req = (m == 2);
            event_req = 1'b1;
            @(negedge mclk);
            event_req = 1'b0;
            wt(3, 150, ok);
            chk("notify", ok, m != 2);
            if (m == 2) begin
                chk("sleep pins", {link.pse_oe, link.sico_oe, link.rdy_oe, link.cs_pu_en}, 4'h1);
                sleep_req = 1'b0;
                wt(3, 200, ok);
                chk("late notify", ok, 1'b1);
            end
            chk("supply", sup_seen, fn_en);
            repeat (100) @(negedge mclk);
        end
        $display("test notify done");
        // host powered down: select must float high
        host_off = 1'b1;
        wake_req = 1'b1;
        repeat (12) @(negedge mclk);
        chk("isolated select", link.cs, 1'b1);
        chk("no hold", meas_hold, 1'b0);
        $display("test isolate done");
        // strap: select low across a device reset
        host_off = 1'b0;
        port_bit = 1'b0;
        repeat (12) @(negedge mclk);
        chk("level irq", wake_irq, 1'b1);
        dev_nrst = 1'b0;
        repeat (4) @(negedge mclk);
        dev_nrst = 1'b1;
        repeat (40) @(negedge mclk);
        chk("strap enable", port_on, 1'b1);
        wake_req = 1'b0;
        repeat (16) @(negedge mclk);
        $display("test strap done");
        end_of_test();
    end
endmodule : host_wake_notify_handshake_tb
`default_nettype wire
